/* File: logic/ocm_pkg.sv */
package ocm_pkg;
    // ==========================================================
    // Mode select codes
    localparam logic [2:0] OCM_MODE_OFF    = 3'h0;
    localparam logic [2:0] OCM_MODE_SET    = 3'h1;
    localparam logic [2:0] OCM_MODE_CLR    = 3'h2;
    localparam logic [2:0] OCM_MODE_TOG    = 3'h3;
    localparam logic [2:0] OCM_MODE_DSHOT  = 3'h4;
    localparam logic [2:0] OCM_MODE_DCONT  = 3'h5;
    localparam logic [2:0] OCM_MODE_EPWM   = 3'h6;
    localparam logic [2:0] OCM_MODE_CPWM   = 3'h7;
    // ==========================================================
    // Register byte addresses
    localparam logic [3:0] OCM_ADDR_CTRL   = 4'h0;
    localparam logic [3:0] OCM_ADDR_PRI    = 4'h4;
    localparam logic [3:0] OCM_ADDR_SEC    = 4'h8;
    localparam logic [3:0] OCM_ADDR_STAT   = 4'hC;
    // ==========================================================
    // Field layout and reset values
    localparam int         OCM_MODE_LSB    = 0;
    localparam int         OCM_MODE_W      = 3;
    localparam int         OCM_WIDTH       = 16;
    localparam logic [15:0] OCM_CMP_RST    = 16'h0000;
    localparam logic [15:0] OCM_TMR_RST    = 16'h0000;
    localparam logic [15:0] OCM_TMR_ZERO   = 16'h0000;
    localparam logic [15:0] OCM_TMR_MAX    = 16'hFFFF;
endpackage : ocm_pkg

/* File: logic/ocm_timer.sv */
`timescale 1ns/10ps
// ==========================================================
// Free-running channel timer with end-of-period pulse
module ocm_timer
    import ocm_pkg::*;
#(
    parameter int WIDTH = OCM_WIDTH
) (
    // Clock and control
    input  wire logic             CLK,
    input  wire logic             RST_B,
    input  wire logic             CE,
    input  wire logic             CLR,
    // Count out
    output logic [WIDTH-1:0]      COUNT,
    output logic                  WRAP
);
    // Width must match the package compare constants
    if (WIDTH != OCM_WIDTH) begin : g_bad_width
        $error("ocm_timer: width must match package");
    end

    // Wrap flags the last count of a period
    assign WRAP = (COUNT == OCM_TMR_MAX);

    // Counter, held at zero while cleared and enabled
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            COUNT <= OCM_TMR_RST;
        end else if (CE) begin
            if (CLR) begin
                COUNT <= OCM_TMR_RST;
            end else begin
                COUNT <= COUNT + WIDTH'(1);
            end
        end
    end
endmodule : ocm_timer

/* File: logic/ocm_unit.sv */
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
// ==========================================================
// Summary of operation
// - Mode 000 disables channel, output stays low
// - Mode 001 starts low, primary match sets high
// - Mode 010 starts high, primary match clears
// - Mode 011 toggles on every primary match
// - Mode 100 one pulse: primary rise, secondary fall
// - Mode 101 continuous primary/secondary pulse train
// - Mode 110 high at zero, low at primary
// - Mode 111 high at primary, low at secondary
// - Compare values double-buffered only in PWM modes
// ==========================================================
module ocm_unit
    import ocm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic        CE,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Compare output pin
    output logic             COMPARE_OUTPUT_PIN
);
    // ======================================================
    // Double-compare phase states
    typedef enum logic [2:0] {
        OCM_ARM  = 3'b001,  // Waiting for primary match
        OCM_HIGH = 3'b010,  // Waiting for secondary match
        OCM_DONE = 3'b100   // Single shot finished
    } ocm_phase_t;

    logic [2:0]      compare_mode_select;      // Mode field
    logic [15:0]     primary_compare_value;    // Active primary
    logic [15:0]     secondary_compare_value;  // Active secondary
    logic [15:0]     pri_buf;                  // Buffered primary
    logic [15:0]     sec_buf;                  // Buffered secondary
    logic [15:0]     compare_timer_count;      // Channel timer
    logic            wrap;                     // Last count of period
    logic            rd_ack;                   // Read answered
    ocm_phase_t      phase;                    // Pulse phase
    logic            mode_wr;                  // Control write
    logic            pri_wr;                   // Primary write
    logic            sec_wr;                   // Secondary write
    logic            is_pwm;                   // PWM mode active
    logic            pri_hit;                  // Primary match
    logic            sec_hit;                  // Secondary match
    logic [15:0]     wdata16;                  // Lane-merged data
    logic [15:0]     sel_old;                  // Target of write

    // Bytewise merge of write data
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0]  = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : merge

    // ======================================================
    // Bus decode
    assign mode_wr = AVS_WRITE && (AVS_ADDRESS == OCM_ADDR_CTRL) && AVS_BYTEENABLE[0];
    assign pri_wr  = AVS_WRITE && (AVS_ADDRESS == OCM_ADDR_PRI);
    assign sec_wr  = AVS_WRITE && (AVS_ADDRESS == OCM_ADDR_SEC);
    assign is_pwm  = (compare_mode_select == OCM_MODE_EPWM) ||
                     (compare_mode_select == OCM_MODE_CPWM);
    // Writes complete at once; reads wait one cycle for registered data
    assign AVS_WAITREQUEST = AVS_READ && !rd_ack;

    // Old value seen by a data write
    always_comb begin
        sel_old = is_pwm ? (pri_wr ? pri_buf : sec_buf)
                         : (pri_wr ? primary_compare_value : secondary_compare_value);
        wdata16 = merge(sel_old, AVS_WRITEDATA, AVS_BYTEENABLE);
    end

    // Read acknowledge, one cycle after read rises
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= AVS_READ && !rd_ack;
        end
    end

    // Read data, unmapped reads return zero
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ && !rd_ack) begin
            unique case (AVS_ADDRESS)
                OCM_ADDR_CTRL: AVS_READDATA <= {29'h0, compare_mode_select};
                OCM_ADDR_PRI:  AVS_READDATA <= {16'h0, is_pwm ? pri_buf : primary_compare_value};
                OCM_ADDR_SEC:  AVS_READDATA <= {16'h0, is_pwm ? sec_buf : secondary_compare_value};
                OCM_ADDR_STAT: AVS_READDATA <= {15'h0, COMPARE_OUTPUT_PIN, compare_timer_count};
                default:       AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end

    // ======================================================
    // Mode register
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            compare_mode_select <= OCM_MODE_OFF;
        end else if (mode_wr) begin
            compare_mode_select <= AVS_WRITEDATA[OCM_MODE_LSB +: OCM_MODE_W];
        end
    end

    // Buffered compare values, bus-written in PWM modes, tracking the active values otherwise
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pri_buf <= OCM_CMP_RST;
            sec_buf <= OCM_CMP_RST;
        end else if (!is_pwm) begin
            pri_buf <= primary_compare_value;
            sec_buf <= secondary_compare_value;
        end else begin
            if (pri_wr) pri_buf <= wdata16;
            if (sec_wr) sec_buf <= wdata16;
        end
    end

    // Active compare values: direct outside PWM, period-end load in PWM
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            primary_compare_value   <= OCM_CMP_RST;
            secondary_compare_value <= OCM_CMP_RST;
        end else if (!is_pwm) begin
            if (pri_wr) primary_compare_value   <= wdata16;
            if (sec_wr) secondary_compare_value <= wdata16;
        end else if (CE && wrap) begin
            primary_compare_value   <= pri_buf;
            secondary_compare_value <= sec_buf;
        end
    end

    // ======================================================
    // Channel timer, held clear while disabled
    ocm_timer #(
        .WIDTH (OCM_WIDTH)
    ) u_timer (
        .CLK   (CLK),
        .RST_B (RST_B),
        .CE    (CE),
        .CLR   (compare_mode_select == OCM_MODE_OFF || mode_wr),
        .COUNT (compare_timer_count),
        .WRAP  (wrap)
    );

    assign pri_hit = (compare_timer_count == primary_compare_value);
    assign sec_hit = (compare_timer_count == secondary_compare_value);

    // ======================================================
    // Pulse phase for double-compare modes
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            phase <= OCM_ARM;
        end else if (mode_wr) begin
            phase <= OCM_ARM;
        end else if (CE) begin
            unique case (phase)
                OCM_ARM:  if (pri_hit) phase <= OCM_HIGH;
                OCM_HIGH: if (sec_hit) begin
                    // Continuous mode rearms, single shot stops
                    phase <= (compare_mode_select == OCM_MODE_DCONT) ? OCM_ARM : OCM_DONE;
                end
                OCM_DONE: phase <= OCM_DONE;
                default:  phase <= OCM_ARM;
            endcase
        end
    end

    // Output pin per mode
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            COMPARE_OUTPUT_PIN <= 1'b0;
        end else if (mode_wr) begin
            // Initial level on mode entry
            COMPARE_OUTPUT_PIN <= (AVS_WRITEDATA[OCM_MODE_LSB +: OCM_MODE_W] == OCM_MODE_CLR);
        end else if (CE) begin
            unique case (compare_mode_select)
                OCM_MODE_OFF:   COMPARE_OUTPUT_PIN <= 1'b0;
                OCM_MODE_SET:   if (pri_hit) COMPARE_OUTPUT_PIN <= 1'b1;
                OCM_MODE_CLR:   if (pri_hit) COMPARE_OUTPUT_PIN <= 1'b0;
                OCM_MODE_TOG:   if (pri_hit) COMPARE_OUTPUT_PIN <= !COMPARE_OUTPUT_PIN;
                OCM_MODE_DSHOT,
                OCM_MODE_DCONT: begin
                    if ((phase == OCM_ARM && pri_hit) || (phase == OCM_HIGH && sec_hit)) begin
                        COMPARE_OUTPUT_PIN <= !COMPARE_OUTPUT_PIN;
                    end
                end
                OCM_MODE_EPWM: begin
                    // Zero sets, primary clears and wins when equal
                    if (pri_hit) COMPARE_OUTPUT_PIN <= 1'b0;
                    else if (compare_timer_count == OCM_TMR_ZERO) COMPARE_OUTPUT_PIN <= 1'b1;
                end
                OCM_MODE_CPWM: begin
                    if (sec_hit) COMPARE_OUTPUT_PIN <= 1'b0;
                    else if (pri_hit) COMPARE_OUTPUT_PIN <= 1'b1;
                end
            endcase
        end
    end
endmodule : ocm_unit

/* File: test/ocm_unit_props.sv */
`timescale 1ns/10ps
// ==========================================================
// Bus timing and pin behaviour checks
module ocm_unit_props
    import ocm_pkg::*;
(
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    input wire logic        CE,
    // Bus
    input wire logic [3:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // Pin
    input wire logic        COMPARE_OUTPUT_PIN
);
    logic [2:0] mode_q;   // Last mode written
    logic       fell_q;   // Pulse over since write
    logic       ctl_wr;   // Control write now
    logic [2:0] wmode;    // Mode being written
    logic       pin;      // Short name for the pin
    assign ctl_wr = AVS_WRITE && AVS_ADDRESS == OCM_ADDR_CTRL && AVS_BYTEENABLE[0];
    assign wmode = AVS_WRITEDATA[OCM_MODE_LSB +: OCM_MODE_W];
    assign pin = COMPARE_OUTPUT_PIN;
    // Follow mode; a fall caused by the write itself is ignored
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            mode_q <= OCM_MODE_OFF;
            fell_q <= 1'b0;
        end else if (ctl_wr) begin
            mode_q <= wmode;
            fell_q <= 1'b0;
        end else if ($fell(COMPARE_OUTPUT_PIN) && !$past(ctl_wr)) begin
            fell_q <= 1'b1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Read walk steps
    sequence rd_wait; AVS_READ && AVS_WAITREQUEST; endsequence
    sequence rd_done; AVS_READ && !AVS_WAITREQUEST; endsequence
    rd_walk_a: assert property (rd_wait |=> rd_done) else $error("read answer late");
    wr_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST) else $error("write stalled");
    rd_hold_a: assert property (!AVS_READ && !$past(AVS_READ) |-> $stable(AVS_READDATA))
        else $error("read data moved");
    rst_idle_a: assert property ($rose(RST_B) |-> !pin && AVS_READDATA == 32'h0)
        else $error("not idle after reset");
    off_quiet_a: assert property (mode_q == OCM_MODE_OFF |-> !pin)
        else $error("pin active while off");
    set_init_a: assert property (ctl_wr && wmode == OCM_MODE_SET |=> !pin)
        else $error("set mode not started low");
    set_hold_a: assert property (mode_q == OCM_MODE_SET && pin && !ctl_wr |=> pin)
        else $error("set mode pin dropped");
    clr_init_a: assert property (ctl_wr && wmode == OCM_MODE_CLR |=> pin)
        else $error("clear mode not started high");
    clr_hold_a: assert property (mode_q == OCM_MODE_CLR && !pin && !ctl_wr |=> !pin)
        else $error("clear mode pin rose");
    shot_done_a: assert property (mode_q == OCM_MODE_DSHOT && fell_q |-> !pin)
        else $error("second pulse in one-shot");
endmodule : ocm_unit_props
bind ocm_unit ocm_unit_props u_props (.CLK(CLK), .RST_B(RST_B), .CE(CE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .COMPARE_OUTPUT_PIN(COMPARE_OUTPUT_PIN));

/* File: test/ocm_pin_load.sv */
`timescale 1ns/10ps
// ==========================================================
// Load on the compare pin, counts rising edges
module ocm_pin_load (
    // Watched pin
    input wire logic clk,
    input wire logic pin,
    // Edge count
    output int       rises
);
    int   count_q = 0;    // Rising edges so far
    logic last_q  = 1'b0; // Pin one cycle ago
    assign rises = count_q;
    // Count each low to high step
    always @(posedge clk) begin
        if (pin === 1'b1 && last_q === 1'b0) begin
            count_q <= count_q + 1;
        end
        last_q <= pin;
    end
endmodule : ocm_pin_load

/* File: test/ocm_unit_test.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the compare channel
module ocm_unit_test;
    import ocm_pkg::*;
    logic        clk, rst_b, rd, wr, wait_r, pin;   // Bus and pin wires
    logic [3:0]  addr;                              // Byte address
    logic [31:0] wdata, rdata, got;                 // Data and last read
    int          rises, n_mismatch, tests_run, cyc; // Counters
    ocm_unit uut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_r), .COMPARE_OUTPUT_PIN(pin));
    ocm_pin_load load (.clk(clk), .pin(pin), .rises(rises));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Bus cycles: hold until waitrequest low, then one idle edge
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        do @(posedge clk); while (wait_r !== 1'b0);
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a);
        addr <= a;
        rd <= 1'b1;
        do @(posedge clk); while (wait_r !== 1'b0);
        got = rdata;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus_rd
    // Poll status until the timer sits in a small window, then check pin
    task automatic pin_at(input logic [15:0] t, input logic exp);
        int n = 0;
        do begin
            bus_rd(OCM_ADDR_STAT);
            n++;
        end while ((got[15:0] < t || got[15:0] >= t + 16'h0010) && n < 40000);
        check({31'h0, got[16]}, {31'h0, exp});
    endtask : pin_at
    task automatic t_regs();
        bus_rd(OCM_ADDR_PRI);
        check(got, 32'h0);
        bus_wr(4'h2, 32'h0000_00FF);
        bus_rd(4'h2);
        check(got, 32'h0);
        bus_wr(OCM_ADDR_SEC, 32'h0000_1234);
        bus_rd(OCM_ADDR_SEC);
        check(got, 32'h0000_1234);
        $display("registers done");
    endtask : t_regs
    // Pin early, after primary (0x20), secondary (0x40), moved primary (0x70)
    task automatic t_mode(input logic [2:0] m, input logic [3:0] exp, input int n_rise);
        int r0;
        bus_wr(OCM_ADDR_CTRL, 32'h0);
        bus_wr(OCM_ADDR_PRI, 32'h0020);
        bus_wr(OCM_ADDR_SEC, 32'h0040);
        r0 = rises;
        bus_wr(OCM_ADDR_CTRL, {29'h0, m});
        if (m == OCM_MODE_OFF) begin
            repeat (80) bus_rd(OCM_ADDR_STAT);
            check(got, 32'h0);
        end else begin
            bus_rd(OCM_ADDR_STAT);
            check({31'h0, got[16]}, {31'h0, exp[3]});
            pin_at(16'h0030, exp[2]);
            pin_at(16'h0050, exp[1]);
            // Moved values: direct modes match again, PWM modes wait for period end
            bus_wr(OCM_ADDR_PRI, 32'h0070);
            bus_wr(OCM_ADDR_SEC, 32'h00A0);
            pin_at(16'h0080, exp[0]);
        end
        check(rises - r0, n_rise);
        $display("mode %0d done", m);
    endtask : t_mode
    task automatic t_direct();
        bus_wr(OCM_ADDR_CTRL, 32'h0); bus_wr(OCM_ADDR_PRI, 32'h0020);
        bus_wr(OCM_ADDR_CTRL, {29'h0, OCM_MODE_SET}); bus_wr(OCM_ADDR_PRI, 32'h0060);
        pin_at(16'h0040, 1'b0);
        pin_at(16'h0080, 1'b1);
        $display("direct load done");
    endtask : t_direct
    // New duty waits for the period end
    task automatic t_buf();
        bus_wr(OCM_ADDR_CTRL, 32'h0); bus_wr(OCM_ADDR_PRI, 32'h0020);
        bus_wr(OCM_ADDR_CTRL, {29'h0, OCM_MODE_EPWM}); bus_wr(OCM_ADDR_PRI, 32'h0080);
        bus_rd(OCM_ADDR_PRI);
        check(got, 32'h0000_0080);
        pin_at(16'h0040, 1'b0);
        pin_at(16'hFFE0, 1'b0);
        pin_at(16'h0040, 1'b1);
        pin_at(16'h00A0, 1'b0);
        $display("buffered load done");
    endtask : t_buf
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        rst_b = 1'b0; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0;
        n_mismatch = 0; tests_run = 0; cyc = 0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_regs();
        t_mode(OCM_MODE_OFF, 4'h0, 0);
        t_mode(OCM_MODE_SET, 4'h7, 1);
        t_mode(OCM_MODE_CLR, 4'h8, 1);
        t_mode(OCM_MODE_TOG, 4'h6, 1);
        t_mode(OCM_MODE_DSHOT, 4'h4, 1);
        t_mode(OCM_MODE_DCONT, 4'h5, 2);
        t_mode(OCM_MODE_EPWM, 4'h8, 1);
        t_mode(OCM_MODE_CPWM, 4'h4, 1);
        t_direct();
        t_buf();
        report_and_stop();
    end
endmodule : ocm_unit_test
